// file: shared/wsf_pkg.sv
// Purpose: Constants and types for the weighing indicator serial framer.
// Assumes: Byte-wide UART transmitters and receivers sit outside this block.
// Notes:   Six-character fields send element 5 first; frames send bytes[0] first.
//
// How it works
// - Second port streams the tare frame only when its output setting is 06.
// - With tare output selected, frames repeat with one idle cycle between them, without any request.
// - Status byte bits 0-5 carry the six active-high weight flags.
// - Status bit 6 is always one; bit 7 is zero or even parity.
// - Byte two is the sign, bytes three to eight the weight.
// - Byte nine is N, bytes ten to fifteen carry the tare field.
// - Byte sixteen is T for manual tare, P for preset tare.
// - Bytes seventeen to twenty-two carry gross weight, byte twenty-three is G.
// - Tare frame ends with carriage return 0d as byte twenty-four.
// - Without weight on display, send status, text, tare, T/P, gross, G, CR.
// - The four-character text is blanks, an error or the menu name.
// - In demand mode the first port answers the demand character with weight.
// - In alibi transmit mode a print key press while port one is idle sends alibi number and gross.
// - Single-character commands are taken only when first-port setting is 09.
// - Question mark 3f gets a nine-byte status, sign, weight, CR reply.
// - Digit zero 30 acts as the zero key and sends nothing back.
// - A demand character stores weight in alibi memory, then sends number and weight.
// - Demand character is a setting from 65 to 90, letters A to Z.
// - Uppercase demand makes a new alibi number, lowercase resends the last.
// - Continuous output uses no handshake or acknowledge from the receiver.
package wsf_pkg;
   localparam logic [7:0] P2_SEL_TARE = 8'h06;
   localparam logic [7:0] P1_SEL_DEMAND = 8'h09;
   localparam logic [7:0] P1_SEL_ALIBI = 8'h13;
   localparam logic [7:0] CH_CR = 8'h0d;
   localparam logic [7:0] CH_PLUS = 8'h2b;
   localparam logic [7:0] CH_MINUS = 8'h2d;
   localparam logic [7:0] CH_N = 8'h4e;
   localparam logic [7:0] CH_T = 8'h54;
   localparam logic [7:0] CH_P = 8'h50;
   localparam logic [7:0] CH_G = 8'h47;
   localparam logic [7:0] CH_S = 8'h53;
   localparam logic [7:0] CH_K = 8'h6b;
   localparam logic [7:0] CH_LG = 8'h67;
   localparam logic [7:0] CH_SPACE = 8'h20;
   localparam logic [7:0] CH_QUERY = 8'h3f;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] CASE_OFS = 8'h20;
   localparam logic [7:0] DEMAND_LO = 8'h41;
   localparam logic [7:0] DEMAND_HI = 8'h5a;
   localparam int FRAME_MAX = 24;
   localparam logic [4:0] LEN_TARE = 5'h18;
   localparam logic [4:0] LEN_MSG = 5'h14;
   localparam logic [4:0] LEN_QUERY = 5'h09;
   localparam logic [4:0] LEN_DEMAND = 5'h0f;
   localparam logic [4:0] LEN_RECORD = 5'h13;
   localparam int FLAG_NO_WEIGHT = 0;
   localparam int ST_BIT_ONE = 6;
   localparam int ST_BIT_PAR = 7;
   localparam int POS_WEIGHT = 2;
   localparam int POS_NET = 8;
   localparam int POS_TARE = 9;
   localparam int POS_TARE_KIND = 15;
   localparam int POS_GROSS = 16;
   localparam int POS_GROSS_MARK = 22;
   localparam int POS_END = 23;

   typedef logic [5:0][7:0] wsf_field_t;

   typedef struct packed {
      logic [5:0] flags;
      logic negative;
      wsf_field_t weight;
      wsf_field_t tare;
      logic tare_preset;
      wsf_field_t gross;
      logic [3:0][7:0] menu_txt;
   } wsf_scale_t;

   typedef struct packed {
      logic [7:0] p1_sel;
      logic [7:0] p2_sel;
      logic [7:0] demand_char;
      logic parity_en;
   } wsf_cfg_t;

   typedef struct packed {
      logic [4:0] len;
      logic [FRAME_MAX-1:0][7:0] bytes;
   } wsf_frame_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } wsf_byte_t;

   typedef enum logic [1:0] {
      P1_IDLE = 2'b00,
      P1_STORE = 2'b01,
      P1_GAP = 2'b10
   } wsf_p1_state_t;

   typedef enum logic [1:0] {
      FK_QUERY = 2'b00,
      FK_DEMAND = 2'b01,
      FK_RECORD = 2'b10
   } wsf_kind_t;
endpackage

// file: design/wsf_frame_tx.sv
// Purpose: Sends one latched frame byte by byte to a UART transmitter.
// Assumes: tx_ready comes from a transmitter on the same clock.
// Notes:   The frame is copied at start, so the source may change freely after.
`timescale 1ns/1ps
module wsf_frame_tx
   import wsf_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire wsf_frame_t frame,
   input wire logic tx_ready,
   output wsf_byte_t tx,
   output logic busy
);
   wsf_frame_t buf_ff;
   wsf_frame_t nxt_buf;
   logic [4:0] idx_ff;
   logic [4:0] nxt_idx;
   logic busy_ff;
   logic nxt_busy;
   wsf_byte_t tx_ff;
   wsf_byte_t nxt_tx;

   // ----------------------------------------------------------------
   // Byte sequencing
   // ----------------------------------------------------------------
   always_comb begin
      nxt_buf = buf_ff;
      nxt_idx = idx_ff;
      nxt_busy = busy_ff;
      nxt_tx = tx_ff;
      if (!busy_ff) begin
         if (start) begin
            nxt_buf = frame;
            nxt_idx = 5'h00;
            nxt_busy = 1'b1;
            nxt_tx.valid = 1'b1;
            nxt_tx.data = frame.bytes[0];
         end
      end else if (tx_ff.valid && tx_ready) begin
         if (5'(idx_ff + 5'h01) == buf_ff.len) begin
            nxt_busy = 1'b0;
            nxt_tx.valid = 1'b0;
         end else begin
            // Next byte follows with no gap or filler.
            nxt_idx = 5'(idx_ff + 5'h01);
            nxt_tx.data = buf_ff.bytes[nxt_idx];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         buf_ff <= '0;
         idx_ff <= 5'h00;
         busy_ff <= 1'b0;
         tx_ff <= '0;
      end else begin
         buf_ff <= nxt_buf;
         idx_ff <= nxt_idx;
         busy_ff <= nxt_busy;
         tx_ff <= nxt_tx;
      end
   end

   assign tx = tx_ff;
   assign busy = busy_ff;
endmodule

// file: design/wsf_framer.sv
// Purpose: Frame building for both serial ports and command handling for port one.
// Assumes: Received characters arrive as one-cycle strobes on this clock.
// Notes:   Commands arriving while port one is sending are dropped, except zero.
`timescale 1ns/1ps
module wsf_framer
   import wsf_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire wsf_cfg_t cfg,
   input wire wsf_scale_t scale,
   input wire logic [3:0][7:0] alibi_num,
   input wire logic print_key,
   input wire wsf_byte_t p1_rx,
   input wire logic p1_tx_ready,
   output wsf_byte_t p1_tx,
   input wire logic second_serial_port_ready,
   output wsf_byte_t second_serial_port_tx,
   output logic zero_req,
   output logic alibi_store,
   output logic alibi_new
);
   wsf_p1_state_t st_ff;
   wsf_p1_state_t nxt_st;
   wsf_kind_t kind_ff;
   wsf_kind_t nxt_kind;
   wsf_kind_t pick;
   logic zero_ff;
   logic nxt_zero;
   logic store_ff;
   logic nxt_store;
   logic new_ff;
   logic nxt_new;
   logic key_s1_ff;
   logic key_s2_ff;
   logic key_s3_ff;
   logic key_lvl_ff;
   logic nxt_key_lvl;
   logic key_press;
   logic p1_start;
   logic p1_busy;
   logic p2_start;
   logic p2_busy;
   logic cmd_ok;
   logic is_upper;
   logic is_lower;
   logic demand_ok;
   logic [7:0] st_byte;
   wsf_frame_t p2_frame;
   wsf_frame_t p1_frame;
   wsf_frame_t q_frame;
   wsf_frame_t d_frame;
   wsf_frame_t r_frame;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] status_of(input logic [5:0] flags, input logic par_en);
      logic [7:0] s;
      s = {2'b01, flags};
      s[ST_BIT_ONE] = 1'b1;
      s[ST_BIT_PAR] = par_en ? ^s[6:0] : 1'b0;
      return s;
   endfunction

   function automatic wsf_frame_t put6(input wsf_frame_t f, input int pos, input wsf_field_t v);
      wsf_frame_t r;
      r = f;
      for (int i = 0; i < 6; i++) begin
         r.bytes[pos + i] = v[5 - i];
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Frame contents
   // ----------------------------------------------------------------
   always_comb begin
      st_byte = status_of(scale.flags, cfg.parity_en);
      p2_frame = '0;
      p2_frame.bytes[0] = st_byte;
      if (!scale.flags[FLAG_NO_WEIGHT]) begin
         p2_frame.len = LEN_TARE;
         p2_frame.bytes[1] = scale.negative ? CH_MINUS : CH_PLUS;
         p2_frame = put6(p2_frame, POS_WEIGHT, scale.weight);
         p2_frame.bytes[POS_NET] = CH_N;
         p2_frame = put6(p2_frame, POS_TARE, scale.tare);
         p2_frame.bytes[POS_TARE_KIND] = scale.tare_preset ? CH_P : CH_T;
         p2_frame = put6(p2_frame, POS_GROSS, scale.gross);
         p2_frame.bytes[POS_GROSS_MARK] = CH_G;
         p2_frame.bytes[POS_END] = CH_CR;
      end else begin
         // The text field replaces sign, weight and N, so the frame is shorter.
         p2_frame.len = LEN_MSG;
         for (int i = 0; i < 4; i++) begin
            p2_frame.bytes[1 + i] = scale.menu_txt[3 - i];
         end
         p2_frame = put6(p2_frame, 5, scale.tare);
         p2_frame.bytes[11] = scale.tare_preset ? CH_P : CH_T;
         p2_frame = put6(p2_frame, 12, scale.gross);
         p2_frame.bytes[18] = CH_G;
         p2_frame.bytes[19] = CH_CR;
      end
   end

   always_comb begin
      q_frame = '0;
      q_frame.len = LEN_QUERY;
      q_frame.bytes[0] = st_byte;
      q_frame.bytes[1] = scale.negative ? CH_MINUS : CH_PLUS;
      q_frame = put6(q_frame, POS_WEIGHT, scale.weight);
      q_frame.bytes[POS_NET] = CH_CR;
      d_frame = '0;
      d_frame.len = LEN_DEMAND;
      for (int i = 0; i < 4; i++) begin
         d_frame.bytes[i] = alibi_num[3 - i];
      end
      d_frame.bytes[4] = CH_SPACE;
      d_frame = put6(d_frame, 5, scale.weight);
      d_frame.bytes[11] = CH_SPACE;
      d_frame.bytes[12] = CH_K;
      d_frame.bytes[13] = CH_LG;
      d_frame.bytes[14] = CH_CR;
      r_frame = '0;
      r_frame.len = LEN_RECORD;
      r_frame.bytes[0] = CH_S;
      r_frame.bytes[1] = CH_N;
      r_frame.bytes[2] = CH_SPACE;
      for (int i = 0; i < 4; i++) begin
         r_frame.bytes[3 + i] = alibi_num[3 - i];
      end
      r_frame.bytes[7] = CH_SPACE;
      r_frame = put6(r_frame, 8, scale.gross);
      r_frame.bytes[14] = CH_SPACE;
      r_frame.bytes[15] = CH_K;
      r_frame.bytes[16] = CH_LG;
      r_frame.bytes[17] = CH_G;
      r_frame.bytes[18] = CH_CR;
      if (pick == FK_DEMAND) begin
         p1_frame = d_frame;
      end else if (pick == FK_RECORD) begin
         p1_frame = r_frame;
      end else begin
         p1_frame = q_frame;
      end
   end

   // ----------------------------------------------------------------
   // Print key synchroniser
   // ----------------------------------------------------------------
   // The level only moves when the second and third stages agree.
   always_comb begin
      nxt_key_lvl = (key_s2_ff == key_s3_ff) ? key_s3_ff : key_lvl_ff;
      key_press = nxt_key_lvl && !key_lvl_ff;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         key_s1_ff <= 1'b0;
         key_s2_ff <= 1'b0;
         key_s3_ff <= 1'b0;
         key_lvl_ff <= 1'b0;
      end else begin
         key_s1_ff <= print_key;
         key_s2_ff <= key_s1_ff;
         key_s3_ff <= key_s2_ff;
         key_lvl_ff <= nxt_key_lvl;
      end
   end

   // ----------------------------------------------------------------
   // First port command handling
   // ----------------------------------------------------------------
   always_comb begin
      cmd_ok = p1_rx.valid && (cfg.p1_sel == P1_SEL_DEMAND);
      demand_ok = (cfg.demand_char >= DEMAND_LO) && (cfg.demand_char <= DEMAND_HI);
      is_upper = demand_ok && (p1_rx.data == cfg.demand_char);
      is_lower = demand_ok && (p1_rx.data == 8'(cfg.demand_char + CASE_OFS));
      nxt_st = st_ff;
      nxt_kind = kind_ff;
      nxt_zero = 1'b0;
      nxt_store = 1'b0;
      nxt_new = 1'b0;
      p1_start = 1'b0;
      pick = kind_ff;
      case (st_ff)
         P1_IDLE: begin
            if (cmd_ok && p1_rx.data == CH_ZERO) begin
               nxt_zero = 1'b1;
            end else if (!p1_busy) begin
               if (cmd_ok && p1_rx.data == CH_QUERY) begin
                  pick = FK_QUERY;
                  p1_start = 1'b1;
               end else if (cmd_ok && is_upper) begin
                  // Store first; the new number needs a cycle to settle.
                  nxt_store = 1'b1;
                  nxt_new = 1'b1;
                  nxt_kind = FK_DEMAND;
                  nxt_st = P1_STORE;
               end else if (cmd_ok && is_lower) begin
                  pick = FK_DEMAND;
                  p1_start = 1'b1;
               end else if (key_press && cfg.p1_sel == P1_SEL_ALIBI) begin
                  nxt_store = 1'b1;
                  nxt_new = 1'b1;
                  nxt_kind = FK_RECORD;
                  nxt_st = P1_STORE;
               end
            end
         end
         P1_STORE: begin
            nxt_st = P1_GAP;
         end
         P1_GAP: begin
            p1_start = 1'b1;
            nxt_st = P1_IDLE;
         end
         default: begin
            nxt_st = P1_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff <= P1_IDLE;
         kind_ff <= FK_QUERY;
         zero_ff <= 1'b0;
         store_ff <= 1'b0;
         new_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         kind_ff <= nxt_kind;
         zero_ff <= nxt_zero;
         store_ff <= nxt_store;
         new_ff <= nxt_new;
      end
   end

   // Continuous output never waits for a reply, only for the transmitter.
   assign p2_start = (cfg.p2_sel == P2_SEL_TARE) && !p2_busy;

   // ----------------------------------------------------------------
   // Byte senders
   // ----------------------------------------------------------------
   wsf_frame_tx u_p1_tx (
      .clk(clk),
      .rst(rst),
      .start(p1_start),
      .frame(p1_frame),
      .tx_ready(p1_tx_ready),
      .tx(p1_tx),
      .busy(p1_busy)
   );

   wsf_frame_tx u_p2_tx (
      .clk(clk),
      .rst(rst),
      .start(p2_start),
      .frame(p2_frame),
      .tx_ready(second_serial_port_ready),
      .tx(second_serial_port_tx),
      .busy(p2_busy)
   );

   assign zero_req = zero_ff;
   assign alibi_store = store_ff;
   assign alibi_new = new_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_P2_SEL: assert property ($rose(second_serial_port_tx.valid) |->
      $past(cfg.p2_sel) == P2_SEL_TARE) else $error("Stream started without tare setting.");
   AST_P2_FIRST: assert property (p2_start |=> second_serial_port_tx.valid &&
      second_serial_port_tx.data[ST_BIT_ONE]) else $error("Frame head lacks status bit six.");
   AST_P2_PAR: assert property (p2_start && !cfg.parity_en |=>
      !second_serial_port_tx.data[ST_BIT_PAR]) else $error("Status bit seven set without parity.");
   AST_TARE_END: assert property (p2_start && !scale.flags[FLAG_NO_WEIGHT] |->
      p2_frame.len == LEN_TARE && p2_frame.bytes[POS_END] == CH_CR) else $error("Bad frame end.");
   AST_NET_MARK: assert property (p2_start && !scale.flags[FLAG_NO_WEIGHT] |->
      p2_frame.bytes[POS_NET] == CH_N) else $error("Net mark missing.");
   AST_MSG_LEN: assert property (p2_start && scale.flags[FLAG_NO_WEIGHT] |->
      p2_frame.len == LEN_MSG && p2_frame.bytes[18] == CH_G) else $error("Bad text frame.");
   AST_ZERO: assert property (cmd_ok && p1_rx.data == CH_ZERO && st_ff == P1_IDLE
      && !p1_busy |=> zero_ff && !p1_tx.valid) else $error("Zero command misbehaved.");
   AST_GATE: assert property (p1_rx.valid && cfg.p1_sel != P1_SEL_DEMAND |=>
      !zero_ff && !(store_ff && kind_ff == FK_DEMAND)) else $error("Command taken outside alibi mode.");
   AST_QUERY: assert property (cmd_ok && p1_rx.data == CH_QUERY && st_ff == P1_IDLE
      && !p1_busy |=> p1_tx.valid && p1_tx.data[ST_BIT_ONE]) else $error("No query reply.");
   AST_STORE_FIRST: assert property (cmd_ok && is_upper && st_ff == P1_IDLE && !p1_busy
      |=> store_ff && new_ff ##1 !p1_tx.valid ##1 p1_tx.valid) else $error("Store order wrong.");
   AST_LOWER: assert property (cmd_ok && is_lower && st_ff == P1_IDLE && !p1_busy
      |=> !new_ff && p1_tx.valid) else $error("Resend made a new number.");

   COV_TARE: cover property (p2_start && !scale.flags[FLAG_NO_WEIGHT]);
   COV_TEXT: cover property (p2_start && scale.flags[FLAG_NO_WEIGHT]);
   COV_DEMAND: cover property (st_ff == P1_GAP && kind_ff == FK_DEMAND);
   COV_RECORD: cover property (st_ff == P1_GAP && kind_ff == FK_RECORD);
endmodule

// file: tb/wsf_host_model.sv
// Purpose: Far-side host model for both serial ports of the framer.
// Assumes: Byte ports hand over a byte at an edge with valid and ready high.
// Notes:   Ready stalls at random when slow is high, to exercise holding.
`timescale 1ns/1ps
module wsf_host_model
   import wsf_pkg::*;
(
   input wire logic clk,
   input wire logic slow,
   input wire wsf_byte_t p1_tx,
   input wire wsf_byte_t p2_tx,
   output logic p1_ready,
   output logic p2_ready,
   output wsf_byte_t p1_rx,
   output wsf_byte_t got1,
   output wsf_byte_t got2
);
   initial begin
      p1_ready = 1'b1;
      p2_ready = 1'b1;
      p1_rx = '0;
      got1 = '0;
      got2 = '0;
   end
   // Ready is only a stall; the host never acknowledges a frame.
   always @(posedge clk) begin
      p1_ready <= !slow || ($urandom % 3 != 0);
      p2_ready <= !slow || ($urandom % 3 != 0);
      got1 <= '{valid: p1_tx.valid && p1_ready, data: p1_tx.data};
      got2 <= '{valid: p2_tx.valid && p2_ready, data: p2_tx.data};
   end
   // One-cycle strobe; data is inverted afterwards so a stale byte is never reused.
   task automatic send_char(input logic [7:0] ch);
      @(posedge clk);
      p1_rx <= '{valid: 1'b1, data: ch};
      @(posedge clk);
      p1_rx <= '{valid: 1'b0, data: ~ch};
   endtask
endmodule

// file: tb/testbench.sv
// Purpose: Self-checking bench for the weighing serial framer.
// Assumes: The host model collects every byte accepted on both ports.
// Notes:   Expected frames are rebuilt here from the scale inputs.
`timescale 1ns/1ps
module testbench;
   import wsf_pkg::*;
   typedef logic [7:0] wsf_bq_t[$];
   logic clk, rst, print_key, slow, zero_req, alibi_store, alibi_new;
   logic p1_ready, p2_ready;
   wsf_cfg_t cfg;
   wsf_scale_t scale;
   logic [3:0][7:0] alibi_num;
   wsf_byte_t p1_rx, p1_tx, p2_tx, got1, got2;
   wsf_bq_t q1, q2;
   int err_total, n_tests, n_zero, n_store, n_new;
   logic [7:0] dc;

   wsf_framer wsf_framer_i (.clk(clk), .rst(rst), .cfg(cfg), .scale(scale),
      .alibi_num(alibi_num), .print_key(print_key), .p1_rx(p1_rx),
      .p1_tx_ready(p1_ready), .p1_tx(p1_tx), .second_serial_port_ready(p2_ready),
      .second_serial_port_tx(p2_tx), .zero_req(zero_req), .alibi_store(alibi_store),
      .alibi_new(alibi_new));
   wsf_host_model wsf_host_model_i (.clk(clk), .slow(slow), .p1_tx(p1_tx), .p2_tx(p2_tx),
      .p1_ready(p1_ready), .p2_ready(p2_ready), .p1_rx(p1_rx), .got1(got1), .got2(got2));

   always #50 clk = ~clk;
   always @(posedge clk) begin
      if (got1.valid) q1.push_back(got1.data);
      if (got2.valid) q2.push_back(got2.data);
      if (zero_req) n_zero++;
      if (alibi_store) n_store++;
      if (alibi_new) n_new++;
   end

   // ----------------------------------------------------------------
   // Expected frames
   // ----------------------------------------------------------------
   function automatic logic [7:0] st();
      logic [6:0] lo;
      lo = {1'b1, scale.flags};
      return {cfg.parity_en & ^lo, lo};
   endfunction
   function automatic wsf_bq_t f6(input wsf_field_t f);
      return {f[5], f[4], f[3], f[2], f[1], f[0]};
   endfunction
   function automatic wsf_bq_t f4(input logic [3:0][7:0] f);
      return {f[3], f[2], f[1], f[0]};
   endfunction
   function automatic wsf_bq_t expect_frame(input int k);
      logic [7:0] sg, tp;
      sg = scale.negative ? CH_MINUS : CH_PLUS;
      tp = scale.tare_preset ? CH_P : CH_T;
      case (k)
         0: return {st(), sg, f6(scale.weight), CH_N, f6(scale.tare), tp, f6(scale.gross),
                    CH_G, CH_CR};
         1: return {st(), f4(scale.menu_txt), f6(scale.tare), tp, f6(scale.gross), CH_G, CH_CR};
         2: return {st(), sg, f6(scale.weight), CH_CR};
         3: return {f4(alibi_num), CH_SPACE, f6(scale.weight), CH_SPACE, CH_K, CH_LG, CH_CR};
         default: return {CH_S, CH_N, CH_SPACE, f4(alibi_num), CH_SPACE, f6(scale.gross),
                          CH_SPACE, CH_K, CH_LG, CH_G, CH_CR};
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Checking tasks
   // ----------------------------------------------------------------
   task automatic stop_test();
      if (err_total == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Bounded wait for a whole frame, then byte-by-byte compare in order.
   task automatic cmp(ref wsf_bq_t q, input wsf_bq_t e, input string nm);
      int k;
      for (k = 0; k < 3000 && q.size() < e.size(); k++) @(posedge clk);
      if (k == 3000) begin
         err_total++;
         $display("ERROR %s expected %0d bytes seen %0d", nm, e.size(), q.size());
         stop_test();
      end
      foreach (e[i]) chk(nm, e[i], q.pop_front());
   endtask
   task automatic rnd_scale();
      scale.flags <= 6'($urandom);
      scale.negative <= 1'($urandom);
      scale.tare_preset <= 1'($urandom);
      for (int i = 0; i < 6; i++) begin
         scale.weight[i] <= 8'h30 + 8'($urandom % 10);
         scale.tare[i] <= 8'h30 + 8'($urandom % 10);
         scale.gross[i] <= 8'h30 + 8'($urandom % 10);
         if (i < 4) scale.menu_txt[i] <= 8'h41 + 8'($urandom % 26);
         if (i < 4) alibi_num[i] <= 8'h30 + 8'($urandom % 10);
      end
      cfg.parity_en <= 1'($urandom);
      @(posedge clk);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      cfg = '{p1_sel: 8'h00, p2_sel: 8'h00, demand_char: 8'h41, parity_en: 1'b0};
      scale = '0;
      alibi_num = '0;
      print_key = 1'b0;
      slow = 1'b0;
      {err_total, n_tests, n_zero, n_store, n_new} = '0;
      void'($urandom(32'hbf2bc16a));
      idle(6);
      rst <= 1'b0;
      idle(2);
      chk("p1_tx.valid", 8'h00, {7'h0, p1_tx.valid});
      chk("p2_tx.valid", 8'h00, {7'h0, p2_tx.valid});
      chk("pulses", 8'h00, {5'h0, zero_req, alibi_store, alibi_new});
      // Stream: weight and text frames, prompt and stalled host, two frames each.
      for (int i = 0; i < 6; i++) begin
         rnd_scale();
         scale.flags[0] <= i[0];
         slow <= i[1];
         idle(1);
         cfg.p2_sel <= P2_SEL_TARE;
         cmp(q2, expect_frame(i % 2), "stream frame");
         cmp(q2, expect_frame(i % 2), "repeat frame");
         cfg.p2_sel <= 8'h01;
         idle(120);
         q2.delete();
      end
      idle(120);
      chk("p2 bytes other mode", 8'h00, 8'(q2.size()));
      // Port one commands in alibi command mode.
      cfg.p1_sel <= P1_SEL_DEMAND;
      slow <= 1'b1;
      rnd_scale();
      wsf_host_model_i.send_char(CH_QUERY);
      cmp(q1, expect_frame(2), "query reply");
      wsf_host_model_i.send_char(CH_ZERO);
      idle(40);
      chk("zero pulses", 8'h01, 8'(n_zero));
      chk("zero reply bytes", 8'h00, 8'(q1.size()));
      for (int i = 0; i < 6; i++) begin
         dc = (i == 0) ? DEMAND_LO : (i == 1) ? DEMAND_HI : DEMAND_LO + 8'($urandom % 26);
         cfg.demand_char <= dc;
         rnd_scale();
         wsf_host_model_i.send_char(dc);
         cmp(q1, expect_frame(3), "demand reply");
         chk("store pulses", 8'(i + 1), 8'(n_store));
         chk("new pulses", 8'(i + 1), 8'(n_new));
         wsf_host_model_i.send_char(dc + CASE_OFS);
         cmp(q1, expect_frame(3), "resend reply");
         chk("resend stores", 8'(i + 1), 8'(n_store));
      end
      // A demand letter outside A to Z is ignored.
      cfg.demand_char <= 8'h5b;
      wsf_host_model_i.send_char(8'h5b);
      idle(40);
      chk("bad demand bytes", 8'h00, 8'(q1.size()));
      chk("bad demand stores", 8'h06, 8'(n_store));
      // Alibi transmit mode: commands ignored, print key sends a record.
      cfg.p1_sel <= P1_SEL_ALIBI;
      rnd_scale();
      wsf_host_model_i.send_char(CH_QUERY);
      wsf_host_model_i.send_char(CH_ZERO);
      idle(60);
      chk("bytes outside cmd mode", 8'h00, 8'(q1.size()));
      chk("zero outside cmd mode", 8'h01, 8'(n_zero));
      print_key <= 1'b1;
      idle(10);
      print_key <= 1'b0;
      cmp(q1, expect_frame(4), "alibi record");
      chk("record stores", 8'h07, 8'(n_store));
      idle(40);
      chk("record length", 8'h00, 8'(q1.size()));
      stop_test();
   end
endmodule
